/* rtl/fuce_engine.sv */
// fuce_engine: command engine for bootloader flash update
// assumes: host issues one command at a time and waits for cmdDone;
// flash port answers each request with flashAck (and flashRdData).
// Behaviour
// - erase erases whole sector holding address
// - erase and write refused while locked
// - chained writes advance address, reduce count
// - never program beyond set-up count
// - read returns requested bytes from address, capped at remaining count
// - reads chain; exhausted count gives failure
// - checksum takes start and byte count
// - returns byte sum and sum of sums
// - flash reset on chip select, abort sequence
// - update lock locked after reset
// - unlock only with key, else lock
`timescale 1ns/1ps
module fuce_engine (
  // clock, reset, enable
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  // command from host
  input  wire logic                       cmdValid,
  output logic                            cmdReady,
  input  wire fuce_pkg::fuce_cmd_t        cmd,
  // write payload bytes from host
  input  wire logic                       payValid,
  output logic                            payReady,
  input  wire logic [7:0]                 payData,
  input  wire logic                       payLast,
  // return bytes to host
  output logic                            retValid,
  input  wire logic                       retReady,
  output logic [7:0]                      retData,
  // completion
  output logic                            cmdDone,
  output logic                            cmdFail,
  output logic                            unlocked,
  // flash port
  output fuce_pkg::fuce_flash_req_t       flashReq,
  output logic                            flashReqValid,
  input  wire logic                       flashAck,
  input  wire logic [7:0]                 flashRdData
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    fuce_pkg::fuce_state_t     state;
    logic                      unlocked;
    logic [31:0]               addr;
    logic [31:0]               remain;
    logic [31:0]               sumAddr;
    logic [31:0]               sumCnt;
    logic [31:0]               simple;
    logic [31:0]               sumOfSum;
    logic [15:0]               rdLeft;
    logic [2:0]                retIdx;
    logic                      fail;
    logic                      done;
    logic                      payEnd;
    fuce_pkg::fuce_flash_req_t req;
    logic                      reqValid;
  } fuce_st_t;

  fuce_st_t   st_q;
  fuce_st_t   st_d;
  logic       fifoInValid;
  logic       fifoInReady;
  logic       fifoOutValid;
  logic       fifoOutReady;
  logic [7:0] fifoOutData;
  logic [63:0] sumWord;

  // read bytes flow through the FIFO; back-pressure stalls flash reads
  fuce_fifo #(
    .WIDTH (8),
    .DEPTH (fuce_pkg::FIFO_DEPTH)
  ) u_retFifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (st_q.state == fuce_pkg::ST_RET ? sumWord[63:56]
               : flashRdData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // host- and flash-facing outputs
  assign sumWord       = {st_q.simple, st_q.sumOfSum} << {st_q.retIdx, 3'h0};
  assign retValid      = fifoOutValid;
  assign retData       = fifoOutData;
  assign fifoOutReady  = retReady;
  assign cmdReady      = (st_q.state == fuce_pkg::ST_IDLE) && !st_q.done;
  assign cmdDone       = st_q.done;
  assign cmdFail       = st_q.fail;
  assign unlocked      = st_q.unlocked;
  assign flashReq      = st_q.req;
  assign flashReqValid = st_q.reqValid;
  assign payReady      = (st_q.state == fuce_pkg::ST_WRITE) && !st_q.reqValid;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    fifoInValid = 1'b0;
    st_d.done   = 1'b0;
    case (st_q.state)
      fuce_pkg::ST_IDLE: begin
        if (cmdValid && !st_q.done) begin
          st_d.fail = 1'b0;
          st_d.req  = '0;
          st_d.state = fuce_pkg::ST_DONE;
          case (cmd.opcode)
            fuce_pkg::OP_UNLOCK: begin
              st_d.unlocked = (cmd.param0 == fuce_pkg::UNLOCK_KEY);
            end
            fuce_pkg::OP_ERASE: begin
              if (!st_q.unlocked) begin
                st_d.fail = 1'b1;
              end else begin
                st_d.req.erase = 1'b1;
                st_d.req.addr  = cmd.param0 & fuce_pkg::SECTOR_MASK;
                st_d.reqValid  = 1'b1;
                st_d.state     = fuce_pkg::ST_ERASE;
              end
            end
            fuce_pkg::OP_SETUP: begin
              st_d.addr   = cmd.param0;
              st_d.remain = cmd.param1;
            end
            fuce_pkg::OP_WRITE: begin
              if (cmd.isRead) begin
                if (st_q.remain == '0) begin
                  st_d.fail = 1'b1;
                end else begin
                  st_d.rdLeft = (cmd.param0[31:16] > st_q.remain) ?
                    st_q.remain[15:0] : cmd.param0[31:16];
                  st_d.state  = fuce_pkg::ST_READ;
                end
              end else if (!st_q.unlocked || st_q.remain == '0) begin
                st_d.fail   = 1'b1;
                st_d.payEnd = 1'b0;
                st_d.state  = fuce_pkg::ST_WRITE; // drain payload
              end else begin
                st_d.payEnd = 1'b0;
                st_d.state  = fuce_pkg::ST_WRITE;
              end
            end
            fuce_pkg::OP_CHECKSUM: begin
              st_d.sumAddr  = cmd.param0;
              st_d.sumCnt   = cmd.param1;
              st_d.simple   = '0;
              st_d.sumOfSum = '0;
              st_d.retIdx   = '0;
              st_d.state    = (cmd.param1 == '0) ? fuce_pkg::ST_RET
                              : fuce_pkg::ST_SUM;
            end
            fuce_pkg::OP_FRESET: begin
              if (cmd.param0[31:24] > {6'h00, fuce_pkg::MAX_CS}) begin
                st_d.fail = 1'b1;
              end else begin
                st_d.req.reset   = 1'b1;
                st_d.req.chipSel = cmd.param0[25:24];
                st_d.reqValid    = 1'b1;
                st_d.state       = fuce_pkg::ST_ERASE;
              end
            end
            default: st_d.fail = 1'b1;
          endcase
        end
      end
      fuce_pkg::ST_ERASE: begin
        if (flashAck) begin
          st_d.reqValid = 1'b0;
          st_d.state    = fuce_pkg::ST_DONE;
        end
      end
      fuce_pkg::ST_WRITE: begin
        if (st_q.reqValid) begin
          if (flashAck) begin
            st_d.reqValid = 1'b0;
            st_d.addr     = st_q.addr + fuce_pkg::ONE32;
            st_d.remain   = st_q.remain - fuce_pkg::ONE32;
            if (st_q.payEnd) st_d.state = fuce_pkg::ST_DONE;
          end
        end else if (payValid) begin
          st_d.payEnd = payLast;
          if (!st_q.fail && st_q.remain != '0) begin
            st_d.req       = '0;
            st_d.req.write = 1'b1;
            st_d.req.addr  = st_q.addr;
            st_d.req.data  = payData;
            st_d.reqValid  = 1'b1;
          end else if (payLast) begin
            st_d.state = fuce_pkg::ST_DONE; // excess discarded
          end
        end
      end
      fuce_pkg::ST_READ: begin
        if (st_q.rdLeft == '0) begin
          st_d.state = fuce_pkg::ST_DONE;
        end else if (!st_q.reqValid && fifoInReady) begin
          st_d.req      = '0;
          st_d.req.read = 1'b1;
          st_d.req.addr = st_q.addr;
          st_d.reqValid = 1'b1;
        end else if (st_q.reqValid && flashAck) begin
          fifoInValid   = 1'b1; // FIFO ready checked at issue
          st_d.reqValid = 1'b0;
          st_d.rdLeft   = st_q.rdLeft - fuce_pkg::ONE16;
          st_d.addr     = st_q.addr + fuce_pkg::ONE32;
          st_d.remain   = st_q.remain - fuce_pkg::ONE32;
        end
      end
      fuce_pkg::ST_SUM: begin
        if (!st_q.reqValid) begin
          st_d.req      = '0;
          st_d.req.read = 1'b1;
          st_d.req.addr = st_q.sumAddr;
          st_d.reqValid = 1'b1;
        end else if (flashAck) begin
          st_d.reqValid = 1'b0;
          st_d.simple   = st_q.simple + {24'h0, flashRdData};
          st_d.sumOfSum = st_q.sumOfSum + st_q.simple
                          + {24'h0, flashRdData};
          st_d.sumAddr  = st_q.sumAddr + fuce_pkg::ONE32;
          st_d.sumCnt   = st_q.sumCnt - fuce_pkg::ONE32;
          if (st_q.sumCnt == fuce_pkg::ONE32) st_d.state = fuce_pkg::ST_RET;
        end
      end
      fuce_pkg::ST_RET: begin
        // simple sum first, big-endian within each word
        if (fifoInReady) begin
          fifoInValid = 1'b1;
          st_d.retIdx = st_q.retIdx + 3'h1;
          if (st_q.retIdx == 3'h7) st_d.state = fuce_pkg::ST_DONE;
        end
      end
      fuce_pkg::ST_DONE: begin
        st_d.done  = 1'b1;
        st_d.req   = '0;
        st_d.state = fuce_pkg::ST_IDLE;
      end
      default: st_d.state = fuce_pkg::ST_IDLE;
    endcase
  end

  // registered state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q       <= '0;
      st_q.state <= fuce_pkg::ST_IDLE;
      st_q.unlocked <= 1'b0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_lockedUpdate;
    cmdValid && cmdReady && !unlocked
      && (cmd.opcode == fuce_pkg::OP_ERASE
          || (cmd.opcode == fuce_pkg::OP_WRITE && !cmd.isRead));
  endsequence

  a_locked_no_flash: assert property (
    s_lockedUpdate |=> !flashReqValid [*2])
    else $error("update issued while locked");
  a_erase_sector: assert property (
    flashReqValid && flashReq.erase |-> flashReq.addr[15:0] == 16'h0000)
    else $error("erase address not sector aligned");
  a_unlock_key: assert property (
    cmdValid && cmdReady && cmd.opcode == fuce_pkg::OP_UNLOCK |=>
      unlocked == ($past(cmd.param0) == fuce_pkg::UNLOCK_KEY))
    else $error("unlock state wrong");
  a_write_bound: assert property (
    flashReqValid && flashReq.write |-> st_q.remain != '0)
    else $error("write beyond set-up count");
  a_write_advance: assert property (
    st_q.state == fuce_pkg::ST_WRITE && flashReqValid && flashAck |=>
      st_q.addr == $past(st_q.addr) + 1)
    else $error("write address not advanced");
  a_read_empty_fail: assert property (
    cmdValid && cmdReady && cmd.opcode == fuce_pkg::OP_WRITE
      && cmd.isRead && st_q.remain == '0 |=> ##1 cmdDone && cmdFail)
    else $error("exhausted read not failed");
  a_reset_cs: assert property (
    flashReqValid && flashReq.reset |-> flashReq.chipSel <= fuce_pkg::MAX_CS)
    else $error("flash reset on bad select");
  a_sum_of_sum: assert property (
    st_q.state == fuce_pkg::ST_SUM && flashReqValid && flashAck |=>
      st_q.sumOfSum == $past(st_q.sumOfSum) + st_q.simple)
    else $error("sum of sums wrong");
endmodule

/* rtl/fuce_fifo.sv */
// fuce_fifo: small synchronous FIFO with valid/ready on both sides
// assumes: single clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
module fuce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
  } fuce_fifo_st_t;

  fuce_fifo_st_t          st_q;
  fuce_fifo_st_t          st_d;
  logic [WIDTH-1:0]       mem [DEPTH];
  logic                   push;
  logic                   pop;

  // honest full and empty
  assign inReady  = (st_q.count != (AW+1)'(DEPTH));
  assign outValid = (st_q.count != '0);
  assign outData  = mem[st_q.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // next pointers
  always_comb begin
    st_d = st_q;
    if (push) st_d.wrPtr = st_q.wrPtr + AW'(1);
    if (pop) st_d.rdPtr = st_q.rdPtr + AW'(1);
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state and storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
      if (push) mem[st_q.wrPtr] <= inData;
    end
  end
endmodule

/* rtl/fuce_pkg.sv */
// fuce_pkg: shared constants and carrier types of the flash update engine
// assumes: one 200 MHz clock, synchronous active-high reset
package fuce_pkg;

  // ------------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_UNLOCK   = 8'h22;
  localparam logic [7:0] OP_ERASE    = 8'h23;
  localparam logic [7:0] OP_SETUP    = 8'h24;
  localparam logic [7:0] OP_WRITE    = 8'h25;
  localparam logic [7:0] OP_READ     = 8'h25; // write opcode with isRead set
  localparam logic [7:0] OP_CHECKSUM = 8'h26;
  localparam logic [7:0] OP_FRESET   = 8'h27;

  // ------------------------------------------------------------------
  // constants
  // ------------------------------------------------------------------
  localparam logic [31:0] UNLOCK_KEY  = 32'hF7A5_4027; // 4154802215
  localparam logic [31:0] SECTOR_MASK = 32'hFFFF_0000; // 64KB sectors
  localparam logic [1:0]  MAX_CS      = 2'h2;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [31:0] ONE32       = 32'h0000_0001;
  localparam logic [15:0] ONE16       = 16'h0001;
  localparam logic [1:0]  BYTE_LAST   = 2'h3;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  // command from host: opcode, up to two 32-bit params, read flag
  typedef struct packed {
    logic [7:0]  opcode;
    logic        isRead;  // 25h carries read when set
    logic [31:0] param0;
    logic [31:0] param1;
  } fuce_cmd_t;

  // flash access request toward the flash port
  typedef struct packed {
    logic        erase;
    logic        write;
    logic        read;
    logic        reset;
    logic [1:0]  chipSel;
    logic [31:0] addr;
    logic [7:0]  data;
  } fuce_flash_req_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ERASE = 7'b0000010,
    ST_WRITE = 7'b0000100,
    ST_READ  = 7'b0001000,
    ST_SUM   = 7'b0010000,
    ST_RET   = 7'b0100000,
    ST_DONE  = 7'b1000000
  } fuce_state_t;

endpackage

/* test/fuce_engine_tb.sv */
// fuce_engine_tb: self-checking bench for the flash update engine
// assumes: package, fifo, engine and flash model compiled first
`timescale 1ns/1ps
module fuce_engine_tb;
  // ------------------------------------------------------------------
  // signals and reference state
  // ------------------------------------------------------------------
  logic sys_clk, rst, cmdValid, cmdReady, payValid, payReady, payLast;
  logic retValid, retReady, cmdDone, cmdFail, unlocked;
  logic flashReqValid, flashAck, locked, hold;
  logic [7:0] payData, retData, flashRdData, rndA;
  logic [7:0] rndB = 8'h31;
  logic [1:0] ackDelay;
  logic [31:0] cur, remain;
  fuce_pkg::fuce_cmd_t       cmd;
  fuce_pkg::fuce_flash_req_t flashReq;
  logic [7:0]  mem [logic [31:0]];
  logic [7:0]  pay [$];
  logic [63:0] expF [$], expR [$], expD [$];
  int          nMismatch, checksDone;

  fuce_engine fuce_engine_i (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .payValid(payValid), .payReady(payReady), .payData(payData),
    .payLast(payLast), .retValid(retValid), .retReady(retReady),
    .retData(retData), .cmdDone(cmdDone), .cmdFail(cmdFail),
    .unlocked(unlocked), .flashReq(flashReq),
    .flashReqValid(flashReqValid), .flashAck(flashAck),
    .flashRdData(flashRdData));

  fuce_flash_model fuce_flash_model_i (.sys_clk(sys_clk),
    .flashReq(flashReq), .flashReqValid(flashReqValid),
    .ackDelay(ackDelay), .flashAck(flashAck), .flashRdData(flashRdData));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] rdm(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // fields that matter for each kind of flash request
  function automatic logic [45:0] fkey(input fuce_pkg::fuce_flash_req_t r);
    return {r.erase, r.write, r.read, r.reset, r.reset ? r.chipSel : 2'h0,
            r.reset ? 32'h0 : r.addr, r.write ? r.data : 8'h0};
  endfunction

  function automatic logic [63:0] pop(ref logic [63:0] q [$]);
    return (q.size() > 0) ? q.pop_front() : 'x;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic finalReport();
    if (expF.size() + expR.size() + expD.size() != 0) nMismatch++;
    if (nMismatch == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one command: request, payload, then bounded wait for completion
  task automatic doCmd(input logic [7:0] op, input logic rd,
                       input logic [31:0] p0, input logic [31:0] p1,
                       input logic fl);
    int n;
    expD.push_back(64'(fl));
    cmd      = '{op, rd, p0, p1};
    cmdValid = 1'b1;
    #1;
    while (!cmdReady) begin @(negedge sys_clk); #1; end
    @(negedge sys_clk);
    cmdValid = 1'b0;
    if (op == fuce_pkg::OP_WRITE && !rd) begin
      foreach (pay[i]) begin
        payValid = 1'b1;
        payData  = pay[i];
        payLast  = (i == pay.size() - 1);
        #1;
        while (!payReady) begin @(negedge sys_clk); #1; end
        @(negedge sys_clk);
      end
      payValid = 1'b0;
      payLast  = 1'b0;
    end
    n = 0;
    while (!cmdDone && n < 4000) begin @(negedge sys_clk); n++; end
    chk(64'(cmdDone), 64'h1);
    chk(64'(unlocked), 64'(!locked));
    @(negedge sys_clk);
  endtask

  task automatic su(input logic [31:0] a, input logic [31:0] n);
    cur    = a;
    remain = n;
    doCmd(fuce_pkg::OP_SETUP, 1'b0, a, n, 1'b0);
  endtask

  // write n random bytes; only the remaining count reaches flash
  task automatic wr(input int n);
    logic fl;
    fl = locked || remain == 32'h0;
    pay.delete();
    repeat (n) begin
      rndA = lf(rndA);
      pay.push_back(rndA);
      if (!fl && remain != 32'h0) begin
        mem[cur] = rndA;
        expF.push_back(64'({4'b0100, 2'h0, cur, rndA}));
        cur++;
        remain--;
      end
    end
    doCmd(fuce_pkg::OP_WRITE, 1'b0, 32'h0, 32'h0, fl);
  endtask

  task automatic rd(input int len);
    logic fl;
    fl = remain == 32'h0;
    repeat (len) begin
      if (remain != 32'h0) begin
        expF.push_back(64'({4'b0010, 2'h0, cur, 8'h0}));
        expR.push_back(64'(rdm(cur)));
        cur++;
        remain--;
      end
    end
    doCmd(fuce_pkg::OP_READ, 1'b1, {16'(len), 16'h0}, 32'h0, fl);
  endtask

  // both sums worked out here, returned most significant byte first
  task automatic cks(input logic [31:0] a, input int n);
    logic [31:0] s, ss;
    s  = 32'h0;
    ss = 32'h0;
    for (int i = 0; i < n; i++) begin
      expF.push_back(64'({4'b0010, 2'h0, a + 32'(i), 8'h0}));
      s  = s + 32'(rdm(a + 32'(i)));
      ss = ss + s;
    end
    for (int i = 3; i >= 0; i--) expR.push_back(64'(s[8*i +: 8]));
    for (int i = 3; i >= 0; i--) expR.push_back(64'(ss[8*i +: 8]));
    doCmd(fuce_pkg::OP_CHECKSUM, 1'b0, a, 32'(n), 1'b0);
  endtask

  task automatic er(input logic [31:0] a);
    if (!locked)
      expF.push_back(64'({4'b1000, 2'h0, a & fuce_pkg::SECTOR_MASK, 8'h0}));
    doCmd(fuce_pkg::OP_ERASE, 1'b0, a, 32'h0, locked);
  endtask

  task automatic rs(input logic [1:0] c);
    if (c <= 2'h2) expF.push_back(64'({4'b0001, c, 32'h0, 8'h0}));
    doCmd(fuce_pkg::OP_FRESET, 1'b0, {6'h0, c, 24'h0}, 32'h0, c > 2'h2);
  endtask

  task automatic ul(input logic [31:0] k);
    locked = k != fuce_pkg::UNLOCK_KEY;
    doCmd(fuce_pkg::OP_UNLOCK, 1'b0, k, 32'h0, 1'b0);
  endtask

  // ------------------------------------------------------------------
  // clock, stalls and result watcher
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // random return stalls and flash answer delays
  always @(negedge sys_clk) begin
    rndB     = lf(rndB);
    retReady <= !hold && rndB[0];
    ackDelay <= rndB[3:2];
  end

  // compare each result with the oldest note
  always @(posedge sys_clk) begin
    if (flashReqValid && flashAck) chk(64'(fkey(flashReq)), pop(expF));
    if (retValid && retReady) chk(64'(retData), pop(expR));
    if (cmdDone) chk(64'(cmdFail), pop(expD));
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    nMismatch++;
    finalReport();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1; cmdValid = 1'b0; payValid = 1'b0; payLast = 1'b0;
    payData = 8'h0; cmd = '0;
    hold = 1'b0; locked = 1'b1; rndA = 8'h31;
    cur = 32'h0; remain = 32'h0; nMismatch = 0; checksDone = 0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    er(32'h0001_2344);
    su(32'h0001_0100, 32'h6);
    wr(4);
    ul(32'h0000_1234);
    ul(fuce_pkg::UNLOCK_KEY);
    er(32'h0001_2344);
    su(32'h0001_0100, 32'hC);
    wr(8);
    wr(6);
    wr(2);
    su(32'h0001_0100, 32'hC);
    hold = 1'b1;
    fork
      rd(10);
      begin repeat (80) @(negedge sys_clk); hold = 1'b0; end
    join
    rd(4);
    rd(2);
    cks(32'h0001_00FE, 6);
    for (int c = 0; c < 4; c++) rs(2'(c));
    ul(32'h0);
    er(32'h0002_0000);
    su(32'h0002_0000, 32'h2);
    wr(2);
    finalReport();
  end
endmodule

/* test/fuce_flash_model.sv */
// fuce_flash_model: behavioural flash behind the engine's flash port
// assumes: one request at a time, held by the engine until flashAck
`timescale 1ns/1ps
module fuce_flash_model (
  // clock
  input  wire logic                      sys_clk,
  // request from engine
  input  wire fuce_pkg::fuce_flash_req_t flashReq,
  input  wire logic                      flashReqValid,
  input  wire logic [1:0]                ackDelay,
  // answer to engine
  output logic                           flashAck = 1'b0,
  output logic [7:0]                     flashRdData = 8'hA5
);
  logic [7:0] mem [logic [31:0]];
  logic [31:0] doomed [$];
  int          waitCnt;

  // answer after ackDelay cycles; data line toggles except when answering a read
  always @(posedge sys_clk) begin
    flashAck    <= 1'b0;
    flashRdData <= ~flashRdData;
    if (flashReqValid && !flashAck) begin
      if (waitCnt < int'(ackDelay)) begin
        waitCnt <= waitCnt + 1;
      end else begin
        waitCnt  <= 0;
        flashAck <= 1'b1;
        if (flashReq.write) begin
          mem[flashReq.addr] = flashReq.data;
        end
        if (flashReq.read) begin
          flashRdData <= mem.exists(flashReq.addr) ?
                         mem[flashReq.addr] : 8'hFF;
        end
        // erased bytes read back as all ones
        if (flashReq.erase) begin
          doomed.delete();
          foreach (mem[k]) begin
            if ((k & 32'hFFFF_0000) == (flashReq.addr & 32'hFFFF_0000))
              doomed.push_back(k);
          end
          foreach (doomed[i]) mem.delete(doomed[i]);
        end
      end
    end
  end
endmodule
